// ---- verilog/iost_osc_ctrl.sv ----
// Purpose: Oscillator enables, frequency select, trim and pin reuse,
//          reached over AXI4-Lite.
// Assumes: Oscillators and RC circuit deliver one-cycle tick inputs
//          synchronous to aclk; ticks are slower than aclk.
// Notes:   Clock outputs are tick enables, the pin level is a register.
`timescale 1ns/1ps
`include "iost_regs.svh"

// Notes on behaviour
// RULE1: RC mode drives second oscillator pin with RC clock divided by four; code divides the system clock, internal when source select is one.
// RULE2: RC-with-I/O mode frees second pin as first port bit four.
// RULE3: Internal clock-out mode frees first pin, second pin gives internal/4.
// RULE4: Internal full-I/O mode frees both pins, no clock output.
// RULE5: Fast oscillator on when select nonzero and internal or two-speed.
// RULE6: Control bit two reads fast oscillator stable, read-only.
// RULE7: Slow oscillator on for zero select internal/two-speed, or timers.
// RULE8: Control bit one reads slow oscillator stable, read-only.
// RULE9: Power-up timer, watchdog, clock monitor always run from slow osc.
// RULE10: Control bits six to four pick one of eight internal frequencies.
// RULE11: Seven upper frequencies come from fast oscillator through postscaler.
// RULE12: Reset loads frequency select with 110, giving 4 MHz.
// RULE13: Trim is 5-bit two's complement for fast oscillator, reset zero.
// RULE14: Trim write takes effect at once, no completion indication.
// RULE15: Trim touches only the fast oscillator, never the slow one.
// RULE16: Trim bits seven to five read zero, writes ignored.
// RULE17: One source-select bit picks external mode or internal oscillators.
// RULE18: Source select one uses internal frequency, zero uses mode; reset clears.
// RULE19: Select 111 is 8 MHz, halving down to 001, 000 is slow.
module iost_osc_ctrl #(
   parameter int STABLE_TICKS = 4
) (
   input wire logic aclk, // 10 MHz clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [`IOST_ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [`IOST_ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic fast_osc_tick, // Fast oscillator edge, 8 MHz nominal
   input wire logic slow_osc_tick, // Slow oscillator edge, 31 kHz
   input wire logic rc_osc_tick, // External RC oscillator edge
   input wire logic ext_osc_tick, // Other external source edge
   output logic fast_internal_osc_en, // Fast oscillator power
   output logic slow_internal_osc_en, // Slow oscillator power
   output logic [`IOST_TRIM_W-1:0] fast_osc_trim, // Trim to fast osc
   output logic sys_clk_tick, // System clock enable
   output logic slow_domain_tick, // Timer, watchdog, monitor clock
   input wire logic port_a_line_four_out, // Port bit four drive value
   input wire logic port_a_line_four_oe, // Port bit four drive enable
   input wire logic osc_pin_first_io_out, // Port drive on first pin
   input wire logic osc_pin_first_io_oe, // Port enable on first pin
   output logic osc_pin_first_out, // First oscillator pin value
   output logic osc_pin_first_oe, // First oscillator pin enable
   output logic osc_pin_first_is_io, // First pin given to port
   output logic osc_pin_second_out, // Second oscillator pin value
   output logic osc_pin_second_oe, // Second oscillator pin enable
   output logic osc_pin_second_is_io // Second pin given to port
);
   import iost_pkg::*;

   logic aw_held_r, w_held_r;
   logic [`IOST_ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_go;
   logic [2:0] fsel_r;
   logic src_sel_r;
   logic [`IOST_TRIM_W-1:0] trim_r;
   logic [7:0] cfg_r;
   logic [$clog2(STABLE_TICKS+1)-1:0] fast_ok_cnt_r, slow_ok_cnt_r;
   logic fast_ok, slow_ok;
   logic [6:0] post_cnt_r;
   logic [6:0] post_mask;
   logic int_tick;
   logic ext_tick;
   logic div4_cnt_r;
   logic divided_clock_output_r;
   logic two_speed_en, pwrup_en, wdog_en, clkmon_en;
   logic [2:0] mode_bits;
   iost_mode_t mode;
   logic [31:0] rd_word;
   logic rd_hit;

   assign two_speed_en = cfg_r[`IOST_CFG_TWO_SPEED];
   assign pwrup_en = cfg_r[`IOST_CFG_PWRUP];
   assign wdog_en = cfg_r[`IOST_CFG_WDOG];
   assign clkmon_en = cfg_r[`IOST_CFG_CLKMON];
   assign mode_bits = cfg_r[`IOST_CFG_MODE_HI:`IOST_CFG_MODE_LO];

   always_comb begin
      case (mode_bits)
         `IOST_MODE_RC: mode = IOST_RC;
         `IOST_MODE_RC_IO: mode = IOST_RC_IO;
         `IOST_MODE_INTCLK: mode = IOST_INT_DIVIDED_CLOCK_OUTPUT;
         `IOST_MODE_INTIO: mode = IOST_INT_IO;
         default: mode = IOST_EXT_OTHER;
      endcase
   end

   // Write channel: address and data taken in either order
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IOST_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_r == `IOST_OFF_CTRL || aw_addr_r == `IOST_OFF_TRIM ||
                aw_addr_r == `IOST_OFF_CFG)
               s_axi_bresp <= `IOST_RESP_OKAY;
            else
               s_axi_bresp <= `IOST_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control register; stable bits are not storage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fsel_r <= `IOST_FSEL_RESET; // [RULE12]
         src_sel_r <= 1'b0; // [RULE18]
      end else if (wr_go && aw_addr_r == `IOST_OFF_CTRL && w_strb_r[0]) begin
         fsel_r <= w_data_r[`IOST_CTRL_FSEL_HI:`IOST_CTRL_FSEL_LO]; // [RULE10]
         src_sel_r <= w_data_r[`IOST_CTRL_SRC_SEL]; // [RULE17]
      end
   end

   // Trim goes straight to the oscillator; it settles on its own
   always_ff @(posedge aclk) begin
      if (!aresetn)
         trim_r <= `IOST_TRIM_RESET; // [RULE13]
      else if (wr_go && aw_addr_r == `IOST_OFF_TRIM && w_strb_r[0])
         trim_r <= w_data_r[`IOST_TRIM_W-1:0]; // [RULE14] [RULE16]
   end
   assign fast_osc_trim = trim_r; // [RULE15]

   always_ff @(posedge aclk) begin
      if (!aresetn)
         cfg_r <= `IOST_CFG_RESET;
      else if (wr_go && aw_addr_r == `IOST_OFF_CFG && w_strb_r[0])
         cfg_r <= w_data_r[7:0];
   end

   // Read channel, one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `IOST_OFF_CTRL: begin
            rd_word[`IOST_CTRL_FSEL_HI:`IOST_CTRL_FSEL_LO] = fsel_r;
            rd_word[`IOST_CTRL_FAST_OK] = fast_ok; // [RULE6]
            rd_word[`IOST_CTRL_SLOW_OK] = slow_ok; // [RULE8]
            rd_word[`IOST_CTRL_SRC_SEL] = src_sel_r;
         end
         `IOST_OFF_TRIM: rd_word[`IOST_TRIM_W-1:0] = trim_r; // [RULE16]
         `IOST_OFF_CFG: rd_word[7:0] = cfg_r;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `IOST_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? `IOST_RESP_OKAY : `IOST_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Oscillator enables; internal modes count as internal selection
   logic int_sel;
   assign int_sel = src_sel_r || mode == IOST_INT_DIVIDED_CLOCK_OUTPUT ||
                    mode == IOST_INT_IO;
   assign fast_internal_osc_en = (fsel_r != `IOST_FSEL_SLOW) &&
                                 (int_sel || two_speed_en); // [RULE5]
   assign slow_internal_osc_en = ((fsel_r == `IOST_FSEL_SLOW) &&
                                  (int_sel || two_speed_en)) ||
                                 pwrup_en || wdog_en || clkmon_en; // [RULE7]

   // Stable after a few edges since enable; drops when powered down
   always_ff @(posedge aclk) begin
      if (!aresetn || !fast_internal_osc_en)
         fast_ok_cnt_r <= '0;
      else if (fast_osc_tick && !fast_ok)
         fast_ok_cnt_r <= fast_ok_cnt_r + 1'b1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || !slow_internal_osc_en)
         slow_ok_cnt_r <= '0;
      else if (slow_osc_tick && !slow_ok)
         slow_ok_cnt_r <= slow_ok_cnt_r + 1'b1;
   end
   assign fast_ok = (fast_ok_cnt_r ==
                     STABLE_TICKS[$bits(fast_ok_cnt_r)-1:0]);
   assign slow_ok = (slow_ok_cnt_r ==
                     STABLE_TICKS[$bits(slow_ok_cnt_r)-1:0]);

   // Postscaler: select n divides the fast edge by 2**(7-n)
   assign post_mask = 7'h7F >> fsel_r; // [RULE19]
   always_ff @(posedge aclk) begin
      if (!aresetn)
         post_cnt_r <= 7'h00;
      else if (fast_osc_tick && fast_internal_osc_en)
         post_cnt_r <= post_cnt_r + 7'h01;
   end
   assign int_tick = (fsel_r == `IOST_FSEL_SLOW) ? slow_osc_tick :
                     (fast_osc_tick && fast_internal_osc_en &&
                      ((post_cnt_r & post_mask) == post_mask)); // [RULE11]

   assign ext_tick = (mode == IOST_RC || mode == IOST_RC_IO) ?
                     rc_osc_tick : ext_osc_tick;
   assign sys_clk_tick = int_sel ? int_tick : ext_tick; // [RULE18]

   // Slow domain never sees the trim; source choice gates it only while no timer is on
   assign slow_domain_tick = slow_osc_tick && slow_internal_osc_en; // [RULE9]

   // Divide by four: toggle the pin every second system edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div4_cnt_r <= 1'b0;
         divided_clock_output_r <= 1'b0;
      end else if (sys_clk_tick) begin
         div4_cnt_r <= div4_cnt_r + 1'b1;
         if (div4_cnt_r == `IOST_DIV4_HALF)
            divided_clock_output_r <= !divided_clock_output_r; // [RULE1] [RULE3]
      end
   end

   // Pin ownership by mode
   always_comb begin
      osc_pin_first_is_io = 1'b0;
      osc_pin_second_is_io = 1'b0;
      osc_pin_first_out = 1'b0;
      osc_pin_first_oe = 1'b0;
      osc_pin_second_out = 1'b0;
      osc_pin_second_oe = 1'b0;
      case (mode)
         IOST_RC: begin
            osc_pin_second_out = divided_clock_output_r; // [RULE1]
            osc_pin_second_oe = 1'b1;
         end
         IOST_RC_IO: begin
            osc_pin_second_is_io = 1'b1; // [RULE2]
            osc_pin_second_out = port_a_line_four_out;
            osc_pin_second_oe = port_a_line_four_oe;
         end
         IOST_INT_DIVIDED_CLOCK_OUTPUT: begin
            osc_pin_first_is_io = 1'b1; // [RULE3]
            osc_pin_first_out = osc_pin_first_io_out;
            osc_pin_first_oe = osc_pin_first_io_oe;
            osc_pin_second_out = divided_clock_output_r;
            osc_pin_second_oe = 1'b1;
         end
         IOST_INT_IO: begin
            osc_pin_first_is_io = 1'b1; // [RULE4]
            osc_pin_second_is_io = 1'b1;
            osc_pin_first_out = osc_pin_first_io_out;
            osc_pin_first_oe = osc_pin_first_io_oe;
            osc_pin_second_out = port_a_line_four_out;
            osc_pin_second_oe = port_a_line_four_oe;
         end
         default: ;
      endcase
   end

   fsel_reset_a: assert property (@(posedge aclk) // [RULE12]
      !aresetn |=> fsel_r == `IOST_FSEL_RESET && !src_sel_r)
      else $error("select not 110 after reset");
   fast_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (src_sel_r && fsel_r != `IOST_FSEL_SLOW) |->
      fast_internal_osc_en) // [RULE5]
      else $error("fast osc off while selected");
   slow_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wdog_en || pwrup_en || clkmon_en) |-> slow_internal_osc_en) // [RULE7]
      else $error("slow osc off while timers need it");
   slow_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (slow_osc_tick && wdog_en) |-> slow_domain_tick) // [RULE9]
      else $error("slow domain lost an edge");
   top_freq_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (int_sel && fsel_r == `IOST_FSEL_TOP && fast_osc_tick) |->
      sys_clk_tick) // [RULE19]
      else $error("8 MHz select skipped an edge");
   resistor_cap_io_mode_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
      mode == IOST_RC_IO |-> osc_pin_second_is_io &&
      osc_pin_second_oe == port_a_line_four_oe) // [RULE2]
      else $error("second pin not freed in rc io mode");
   intio_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
      mode == IOST_INT_IO |-> osc_pin_first_is_io &&
      osc_pin_second_is_io) // [RULE4]
      else $error("pins not freed in full io mode");
   divided_clock_output_div_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (sys_clk_tick && div4_cnt_r == `IOST_DIV4_HALF &&
       mode == IOST_RC) |=> osc_pin_second_out != $past(divided_clock_output_r)) // [RULE1]
      else $error("clock output did not toggle");
   trim_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && aw_addr_r == `IOST_OFF_TRIM && w_strb_r[0]) |=>
      fast_osc_trim == $past(w_data_r[`IOST_TRIM_W-1:0])) // [RULE14]
      else $error("trim not applied after write");
   fast_ok_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == `IOST_OFF_CTRL)
      |=> s_axi_rdata[`IOST_CTRL_FAST_OK] == $past(fast_ok)) // [RULE6]
      else $error("fast stable bit misread");

endmodule

// ---- verilog/iost_regs.svh ----
// Purpose: Register map, field positions and reset values of the
//          internal oscillator select and trim block.
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register.
// Notes:   Upper bits of every register read as zero.
`ifndef IOST_REGS_SVH
`define IOST_REGS_SVH

`define IOST_ADDR_W 8
`define IOST_OFF_CTRL 8'h8C
`define IOST_OFF_TRIM 8'h90
`define IOST_OFF_CFG 8'h94

`define IOST_CTRL_SRC_SEL 0
`define IOST_CTRL_SLOW_OK 1
`define IOST_CTRL_FAST_OK 2
`define IOST_CTRL_FSEL_LO 4
`define IOST_CTRL_FSEL_HI 6
`define IOST_FSEL_RESET 3'h6
`define IOST_FSEL_SLOW 3'h0
`define IOST_FSEL_TOP 3'h7

`define IOST_TRIM_W 5
`define IOST_TRIM_RESET 5'h00

`define IOST_CFG_MODE_LO 0
`define IOST_CFG_MODE_HI 2
`define IOST_CFG_TWO_SPEED 4
`define IOST_CFG_PWRUP 5
`define IOST_CFG_WDOG 6
`define IOST_CFG_CLKMON 7
`define IOST_CFG_RESET 8'h00

`define IOST_MODE_EXT 3'h0
`define IOST_MODE_RC 3'h1
`define IOST_MODE_RC_IO 3'h2
`define IOST_MODE_INTCLK 3'h3
`define IOST_MODE_INTIO 3'h4

`define IOST_RESP_OKAY 2'h0
`define IOST_RESP_SLVERR 2'h2
`define IOST_DIV4_HALF 1'h1

`endif

// ---- verilog/iost_pkg.sv ----
// Purpose: Types shared by the oscillator select and trim block.
// Assumes: Numbers live in iost_regs.svh.
// Notes:   Mode decode happens in the top module.
package iost_pkg;
   typedef enum logic [2:0] {
      IOST_EXT_OTHER,
      IOST_RC,
      IOST_RC_IO,
      IOST_INT_DIVIDED_CLOCK_OUTPUT,
      IOST_INT_IO
   } iost_mode_t;
   typedef logic [2:0] iost_fsel_t;
endpackage

// ---- testbench/iost_tb.sv ----
// Purpose: Self-checking bench for the oscillator select and trim block.
// Assumes: Oscillator ticks are pulsed every second aclk cycle.
// Notes:   STABLE_TICKS is cut to 2 so stable flags rise quickly.
`timescale 1ns/1ps
`include "iost_regs.svh"
module testbench;
   import iost_pkg::*;
   logic aclk = 0;
   logic aresetn = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic ft = 0, st = 0, rt = 0;
   logic p4o = 0, p4e = 0, p1o = 0, p1e = 0;
   logic fast_en, slow_en, sys_tick, slow_tick;
   logic [4:0] trim;
   logic p1_out, p1_oe, p1_io, p2_out, p2_oe, p2_io;
   int err_count = 0, check_count = 0;
   int ns, nl, nt, n;
   logic [31:0] d;
   logic [1:0] r;

   always #50 aclk = ~aclk;

   iost_osc_ctrl #(.STABLE_TICKS(2)) iost_osc_ctrl_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fast_osc_tick(ft), .slow_osc_tick(st), .rc_osc_tick(rt),
      .ext_osc_tick(1'b0),
      .fast_internal_osc_en(fast_en), .slow_internal_osc_en(slow_en),
      .fast_osc_trim(trim), .sys_clk_tick(sys_tick),
      .slow_domain_tick(slow_tick),
      .port_a_line_four_out(p4o), .port_a_line_four_oe(p4e),
      .osc_pin_first_io_out(p1o), .osc_pin_first_io_oe(p1e),
      .osc_pin_first_out(p1_out), .osc_pin_first_oe(p1_oe),
      .osc_pin_first_is_io(p1_io), .osc_pin_second_out(p2_out),
      .osc_pin_second_oe(p2_oe), .osc_pin_second_is_io(p2_io)
   );

   task test_done;
      if (err_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Master releases each channel at its own handshake edge
   task wr(input logic [7:0] a, input logic [31:0] v);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid) break;
      end
      if (i == 50) begin
         err_count++;
         test_done;
      end
      bready <= 0;
   endtask

   task rd(input logic [7:0] a);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid) break;
      end
      if (i == 50) begin
         err_count++;
         test_done;
      end
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk("read_data", exp, d);
   endtask

   // Pulses the chosen ticks n times, counting outputs and pin toggles
   task ticks(input int cnt, input logic f, input logic s, input logic c);
      logic last;
      int i;
      ns = 0;
      nl = 0;
      nt = 0;
      last = p2_out;
      for (i = 0; i < 2 * cnt; i++) begin
         @(posedge aclk);
         ft <= f && !i[0];
         st <= s && !i[0];
         rt <= c && !i[0];
         @(negedge aclk);
         ns += sys_tick;
         nl += slow_tick;
         nt += (p2_out !== last);
         last = p2_out;
      end
   endtask

   task t_reset;
      rd_chk(`IOST_OFF_CTRL, 32'h60);
      rd_chk(`IOST_OFF_TRIM, 32'h0);
      chk("osc_enables", 2'b00, {fast_en, slow_en});
      rd(8'h40);
      chk("unmapped_resp", `IOST_RESP_SLVERR, r);
      wr(8'h40, 32'h0);
      chk("unmapped_bresp", `IOST_RESP_SLVERR, bresp);
      wr(`IOST_OFF_TRIM, 32'h0);
      chk("mapped_bresp", `IOST_RESP_OKAY, bresp);
   endtask

   task t_trim;
      wr(`IOST_OFF_TRIM, 32'hFF);
      rd_chk(`IOST_OFF_TRIM, 32'h1F);
      chk("trim_out", 5'h1F, trim);
      wr(`IOST_OFF_TRIM, 32'h10);
      chk("trim_out", 5'h10, trim);
   endtask

   task t_enables;
      wr(`IOST_OFF_CTRL, 32'h71);
      chk("osc_enables", 2'b10, {fast_en, slow_en});
      rd_chk(`IOST_OFF_CTRL, 32'h71);
      ticks(4, 1, 1, 0);
      rd_chk(`IOST_OFF_CTRL, 32'h75);
      wr(`IOST_OFF_CTRL, 32'h07);
      chk("osc_enables", 2'b01, {fast_en, slow_en});
      ticks(4, 1, 1, 0);
      rd_chk(`IOST_OFF_CTRL, 32'h03);
      wr(`IOST_OFF_CTRL, 32'h00);
      wr(`IOST_OFF_CFG, 32'h10);
      chk("osc_enables", 2'b01, {fast_en, slow_en});
      wr(`IOST_OFF_CTRL, 32'h60);
      chk("osc_enables", 2'b10, {fast_en, slow_en});
      for (n = 5; n < 8; n++) begin
         wr(`IOST_OFF_CFG, 32'h1 << n);
         chk("slow_en", 1'b1, slow_en);
      end
   endtask

   task t_freq;
      wr(`IOST_OFF_CFG, 32'h00);
      // Power-of-two windows make the count exact at any divider phase
      for (n = 1; n < 8; n++) begin
         wr(`IOST_OFF_CTRL, (n << 4) | 1);
         ticks(128, 1, 0, 0);
         chk("sys_ticks", 128 >> (7 - n), ns);
      end
      wr(`IOST_OFF_CTRL, 32'h01);
      ticks(16, 1, 1, 0);
      chk("sys_ticks", 16, ns);
   endtask

   task t_slow;
      wr(`IOST_OFF_CFG, 32'h40);
      wr(`IOST_OFF_CTRL, 32'h71);
      wr(`IOST_OFF_TRIM, 32'h0F);
      ticks(8, 1, 1, 0);
      chk("slow_ticks", 8, nl);
      chk("sys_ticks", 8, ns);
   endtask

   task t_pins;
      wr(`IOST_OFF_CFG, 32'h01);
      wr(`IOST_OFF_CTRL, 32'h71);
      ticks(8, 0, 0, 1);
      chk("sys_ticks", 0, ns);
      wr(`IOST_OFF_CTRL, 32'h60);
      ticks(8, 0, 0, 1);
      chk("sys_ticks", 8, ns);
      chk("clk_toggles", 4, nt);
      chk("pin_use", 3'b001, {p1_io, p2_io, p2_oe});
      p4o <= 1;
      p4e <= 1;
      p1o <= 1;
      p1e <= 1;
      wr(`IOST_OFF_CFG, 32'h02);
      ticks(8, 0, 0, 1);
      chk("clk_toggles", 0, nt);
      chk("pin_use", 4'b0111, {p1_io, p2_io, p2_oe, p2_out});
      wr(`IOST_OFF_CFG, 32'h03);
      wr(`IOST_OFF_CTRL, 32'h70);
      ticks(8, 1, 0, 0);
      chk("clk_toggles", 4, nt);
      chk("pin_use", 5'b11101, {p1_io, p1_out, p1_oe, p2_io, p2_oe});
      wr(`IOST_OFF_CFG, 32'h04);
      ticks(8, 1, 0, 0);
      chk("clk_toggles", 0, nt);
      chk("pin_use", 4'b1111, {p1_io, p1_out, p2_io, p2_out});
   endtask

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      t_reset;
      t_trim;
      t_enables;
      t_freq;
      t_slow;
      t_pins;
      test_done;
   end
endmodule
